// *** hw/timer_channel_pkg.sv ***
package timer_channel_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_CV = 8'h10;
    localparam logic [7:0] OFS_RA = 8'h14;
    localparam logic [7:0] OFS_RB = 8'h18;
    localparam logic [7:0] OFS_RC = 8'h1C;
    localparam logic [7:0] OFS_SR = 8'h20;
    localparam logic [7:0] OFS_IER = 8'h24;
    localparam logic [7:0] OFS_IDR = 8'h28;
    localparam logic [7:0] OFS_IMR = 8'h2C;
    // ------------------------------------------------------------
    // Control command bits
    // ------------------------------------------------------------
    localparam int CTRL_CLKEN = 0;
    localparam int CTRL_CLKDIS = 1;
    localparam int CTRL_SWTRG = 2;
    // ------------------------------------------------------------
    // Mode register fields (lsb of each two-bit field; CPCTRG and WAVE are single bits)
    // ------------------------------------------------------------
    localparam int MODE_EEVT = 10;
    localparam int MODE_CPCTRG = 14;
    localparam int MODE_WAVE = 15;
    localparam int MODE_LDRA = 16;
    localparam int MODE_LDRB = 18;
    localparam int MODE_ACPA = 16;
    localparam int MODE_ACPC = 18;
    localparam int MODE_AEEVT = 20;
    localparam int MODE_ASWTRG = 22;
    localparam int MODE_LINE_B_ACTION_ON_MATCH_B = 24;
    localparam int MODE_LINE_B_ACTION_ON_MATCH_C = 26;
    localparam int MODE_LINE_B_ACTION_ON_EXT_EVENT = 28;
    localparam int MODE_LINE_B_ACTION_ON_SOFT_TRIGGER = 30;
    localparam logic [31:0] MODE_RESET = 32'h0000_0000;
    // ------------------------------------------------------------
    // Status bits
    // ------------------------------------------------------------
    localparam int ST_OVF = 0;
    localparam int ST_LOVR = 1;
    localparam int ST_CPA = 2;
    localparam int ST_CPB = 3;
    localparam int ST_CPC = 4;
    localparam int ST_LDA = 5;
    localparam int ST_LDB = 6;
    localparam int ST_ETRG = 7;
    localparam int ST_CLOCK_RUNNING_FLAG = 16;
    localparam int ST_MIRA = 17;
    localparam int ST_MIRB = 18;
    localparam int NUM_FLAGS = 8;
    // ------------------------------------------------------------
    // Line action and edge codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ACT_NONE = 2'h0,
        ACT_SET = 2'h1,
        ACT_CLR = 2'h2,
        ACT_TGL = 2'h3
    } action_t;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam logic [1:0] EEVT_LINE_B = 2'h0;
endpackage : timer_channel_pkg

// *** hw/timer_channel.sv ***
`timescale 1ns/1ns
// How it works
// RULE_01: Waveform mode, match with B applies the line B action code.
// RULE_02: Match with C applies its own line B action code.
// RULE_03: External event applies its own line B action code.
// RULE_04: Software trigger applies its own line B action code.
// RULE_05: Counter value register is read-only, live count, upper bits zero.
// RULE_06: Hold A and B read-only in capture, writable in waveform.
// RULE_07: Hold C is read/write in both modes, sixteen bits.
// RULE_08: Counter overflow sets status bit 0 until status is read.
// RULE_09: Capture: second load of A or B before read sets bit 1.
// RULE_10: Waveform only: bits 2 and 3 flag matches with A and B.
// RULE_11: Bit 4 flags a match with C in both modes.
// RULE_12: Capture only: bits 5 and 6 flag loads of A and B.
// RULE_13: Bit 7 flags an external trigger.
// RULE_14: Flags 7 to 0 are sticky and cleared by a status read.
// RULE_15: Bit 16 reads one while the counter clock is enabled.
// RULE_16: Bit 17 mirrors line A: pin level or driven level.
// RULE_17: Bit 18 mirrors line B the same way.
// RULE_18: Write-only enable register sets enables where ones are written.
// RULE_19: Write-only disable register clears enables where ones are written.
// RULE_20: Read-only mask register reports each enabled source.
// RULE_21: Mode bit one selects waveform, zero selects capture.
// RULE_22: Interrupt output high while any flag and its enable are set.
module timer_channel #(
    parameter int CNT_W = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [31:0] rdata,
    input wire logic countTick,
    input wire logic extEvent,
    input wire logic lineAIn,
    output logic lineAOut,
    output logic lineAOe,
    input wire logic lineBIn,
    output logic lineBOut,
    output logic lineBOe,
    output logic irq
);
    import timer_channel_pkg::*;

    if (CNT_W < 2 || CNT_W > 16) begin : g_chk
        $error("CNT_W must lie between 2 and 16");
    end

    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    function automatic logic applyAct(input logic lv, input logic [1:0] c);
        case (c)
            ACT_SET: return 1'b1;
            ACT_CLR: return 1'b0;
            ACT_TGL: return ~lv;
            default: return lv;
        endcase
    endfunction : applyAct

    function automatic logic edgeHit(input logic [1:0] sel,
                                     input logic rise, input logic fall);
        return (sel[0] & rise) | (sel[1] & fall);
    endfunction : edgeHit

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [31:0] mode_q;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CNT_W-1:0] ra_q, ra_d, rb_q, rb_d, rc_q;
    logic [NUM_FLAGS-1:0] flags_q, flags_d, mask_q;
    logic clkEn_q, unreadA_q, unreadB_q;
    logic lineA_q, lineB_q, lineA_d, lineB_d;
    logic [31:0] rdata_q;
    logic [2:0] syncA_q, syncB_q;
    logic pinA_q, pinB_q, pinAPrev_q;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire wave = mode_q[MODE_WAVE]; // [RULE_21]
    wire wrCtrl = wrStb && addr == OFS_CTRL;
    wire wrMode = wrStb && addr == OFS_MODE;
    wire wrRa = wrStb && addr == OFS_RA && wave; // [RULE_06]
    wire wrRb = wrStb && addr == OFS_RB && wave; // [RULE_06]
    wire wrRc = wrStb && addr == OFS_RC; // [RULE_07]
    wire wrIer = wrStb && addr == OFS_IER;
    wire wrIdr = wrStb && addr == OFS_IDR;
    wire rdSr = rdStb && addr == OFS_SR;
    wire rdRa = rdStb && addr == OFS_RA;
    wire rdRb = rdStb && addr == OFS_RB;
    wire [CNT_W-1:0] wdCnt = wdata[CNT_W-1:0];
    wire [NUM_FLAGS-1:0] wd8 = wdata[NUM_FLAGS-1:0];

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // A change is accepted only once two late stages agree, which
    // also rejects single-cycle glitches on the pins.
    wire pinAD = (syncA_q[1] == syncA_q[2]) ? syncA_q[2] : pinA_q;
    wire pinBD = (syncB_q[1] == syncB_q[2]) ? syncB_q[2] : pinB_q;
    wire riseA = pinA_q & ~pinAPrev_q;
    wire fallA = ~pinA_q & pinAPrev_q;

    // ------------------------------------------------------------
    // Events
    // ------------------------------------------------------------
    wire swTrig = wrCtrl && wdata[CTRL_SWTRG];
    wire tick = countTick && clkEn_q;
    wire ovf = tick && cnt_q == CNT_MAX;
    wire matchA = tick && cnt_q == ra_q && wave;
    wire matchB = tick && cnt_q == rb_q && wave;
    wire matchC = tick && cnt_q == rc_q;
    wire loadA = !wave && edgeHit(mode_q[MODE_LDRA+:2], riseA, fallA);
    wire loadB = !wave && edgeHit(mode_q[MODE_LDRB+:2], riseA, fallA);
    wire overrun = (loadA && unreadA_q) || (loadB && unreadB_q);
    wire trigEv = extEvent || swTrig;
    wire restart = trigEv || (matchC && mode_q[MODE_CPCTRG]);
    wire bIsInput = mode_q[MODE_EEVT+:2] == EEVT_LINE_B;

    wire [NUM_FLAGS-1:0] events = {
        trigEv,         // [RULE_13]
        loadB,          // [RULE_12]
        loadA,          // [RULE_12]
        matchC,         // [RULE_11]
        matchB,         // [RULE_10]
        matchA,         // [RULE_10]
        overrun,        // [RULE_09]
        ovf             // [RULE_08]
    };

    // ------------------------------------------------------------
    // Line actions, one event wins per cycle
    // ------------------------------------------------------------
    // Highest priority first so that two toggles never cancel out.
    wire [1:0] codeA = swTrig ? mode_q[MODE_ASWTRG+:2]
                     : extEvent ? mode_q[MODE_AEEVT+:2]
                     : matchC ? mode_q[MODE_ACPC+:2]
                     : matchA ? mode_q[MODE_ACPA+:2] : ACT_NONE;
    wire [1:0] codeB = swTrig ? mode_q[MODE_LINE_B_ACTION_ON_SOFT_TRIGGER+:2] // [RULE_04]
                     : extEvent ? mode_q[MODE_LINE_B_ACTION_ON_EXT_EVENT+:2] // [RULE_03]
                     : matchC ? mode_q[MODE_LINE_B_ACTION_ON_MATCH_C+:2] // [RULE_02]
                     : matchB ? mode_q[MODE_LINE_B_ACTION_ON_MATCH_B+:2] // [RULE_01]
                     : ACT_NONE;
    assign lineA_d = wave ? applyAct(lineA_q, codeA) : lineA_q;
    assign lineB_d = wave ? applyAct(lineB_q, codeB) : lineB_q;

    // ------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------
    assign cnt_d = restart ? '0 : tick ? cnt_q + 1'b1 : cnt_q;
    assign ra_d = loadA ? cnt_q : wrRa ? wdCnt : ra_q;
    assign rb_d = loadB ? cnt_q : wrRb ? wdCnt : rb_q;
    // Set beats clear so an event in the reading cycle is kept.
    assign flags_d = (rdSr ? '0 : flags_q) | events; // [RULE_14]

    wire mirA = wave ? lineA_q : pinA_q;
    wire mirB = (wave && !bIsInput) ? lineB_q : pinB_q;

    wire [31:0] statusWord = {13'h0000, mirB, mirA, clkEn_q, // [RULE_15]
                              8'h00, flags_q}; // [RULE_16] [RULE_17]

    wire [31:0] rdMux =
        addr == OFS_MODE ? mode_q :
        addr == OFS_CV ? 32'(cnt_q) : // [RULE_05]
        addr == OFS_RA ? 32'(ra_q) :
        addr == OFS_RB ? 32'(rb_q) :
        addr == OFS_RC ? 32'(rc_q) : // [RULE_07]
        addr == OFS_SR ? statusWord :
        addr == OFS_IMR ? 32'(mask_q) : 32'h0000_0000; // [RULE_20]

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            syncA_q <= 3'h0;
            syncB_q <= 3'h0;
            pinA_q <= 1'b0;
            pinB_q <= 1'b0;
            pinAPrev_q <= 1'b0;
        end else begin
            syncA_q <= {syncA_q[1:0], lineAIn};
            syncB_q <= {syncB_q[1:0], lineBIn};
            pinA_q <= pinAD;
            pinB_q <= pinBD;
            pinAPrev_q <= pinA_q;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode_q <= MODE_RESET;
            rc_q <= '0;
            mask_q <= '0;
        end else begin
            if (wrMode) mode_q <= wdata;
            if (wrRc) rc_q <= wdCnt;
            mask_q <= (mask_q | (wrIer ? wd8 : '0)) // [RULE_18]
                      & ~(wrIdr ? wd8 : '0); // [RULE_19]
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            ra_q <= '0;
            rb_q <= '0;
            flags_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            ra_q <= ra_d;
            rb_q <= rb_d;
            flags_q <= flags_d;
        end
    end

    // A restart event starts the clock; the disable command wins
    // over an enable written in the same word.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            clkEn_q <= 1'b0;
        end else if (wrCtrl && wdata[CTRL_CLKDIS]) begin
            clkEn_q <= 1'b0;
        end else if (restart || (wrCtrl && wdata[CTRL_CLKEN])) begin
            clkEn_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            unreadA_q <= 1'b0;
            unreadB_q <= 1'b0;
        end else begin
            unreadA_q <= loadA | (unreadA_q & ~rdRa); // [RULE_09]
            unreadB_q <= loadB | (unreadB_q & ~rdRb); // [RULE_09]
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lineA_q <= 1'b0;
            lineB_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            lineA_q <= lineA_d;
            lineB_q <= lineB_d;
            rdata_q <= rdStb ? rdMux : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata = rdata_q;
    assign lineAOut = lineA_q;
    assign lineAOe = wave;
    assign lineBOut = lineB_q;
    assign lineBOe = wave && !bIsInput;
    assign irq = |(flags_q & mask_q); // [RULE_22]

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence sOvf;
        tick && cnt_q == CNT_MAX;
    endsequence
    sequence sRdCv;
        rdStb && addr == OFS_CV;
    endsequence
    sequence sWrIer;
        wrStb && addr == OFS_IER;
    endsequence
    sequence sNoRead;
        !rdSr [*2];
    endsequence
    sequence sReload;
        (loadA && unreadA_q) || (loadB && unreadB_q);
    endsequence
    sequence sClkOff;
        wrCtrl && wdata[CTRL_CLKDIS];
    endsequence

    a_ovf_sticky: assert property ( // [RULE_08]
        sOvf ##1 sNoRead |-> flags_q[ST_OVF])
        else $error("overflow flag not held");
    a_sr_clear: assert property ( // [RULE_14]
        rdSr && !trigEv |=> !flags_q[ST_ETRG])
        else $error("status read did not clear flag");
    a_cv_live: assert property ( // [RULE_05]
        sRdCv |=> rdata == {16'h0000, 16'($past(cnt_q))})
        else $error("counter value read wrong");
    a_hold_ro: assert property ( // [RULE_06]
        wrStb && addr == OFS_RA && !wave && !loadA |=> $stable(ra_q))
        else $error("hold A written in capture mode");
    a_rc_rw: assert property ( // [RULE_07]
        wrRc ##1 !wrRc ##1 (rdStb && addr == OFS_RC) |=>
            rdata[CNT_W-1:0] == $past(wdCnt, 3))
        else $error("hold C readback wrong");
    a_wave_match: assert property ( // [RULE_10]
        !wave |=> !$rose(flags_q[ST_CPA]) && !$rose(flags_q[ST_CPB]))
        else $error("compare flag in capture mode");
    a_cap_load: assert property ( // [RULE_12]
        wave |=> !$rose(flags_q[ST_LDA]) && !$rose(flags_q[ST_LDB]) &&
            !$rose(flags_q[ST_LOVR]))
        else $error("load flag in waveform mode");
    a_ier_set: assert property ( // [RULE_18]
        sWrIer |=> (mask_q & $past(wd8)) == $past(wd8))
        else $error("enable not set");
    a_idr_clr: assert property ( // [RULE_19]
        wrIdr && !wrIer |=> (mask_q & $past(wd8)) == '0)
        else $error("enable not cleared");
    a_irq_out: assert property ( // [RULE_22]
        flags_q[ST_CPC] && mask_q[ST_CPC] |-> irq)
        else $error("interrupt not raised");
    a_lineb_set: assert property ( // [RULE_01]
        wave && matchB && !matchC && !trigEv &&
        mode_q[MODE_LINE_B_ACTION_ON_MATCH_B+:2] == ACT_SET |=> lineBOut)
        else $error("line B not set on match B");
    a_lineb_tgl: assert property ( // [RULE_04]
        wave && swTrig && mode_q[MODE_LINE_B_ACTION_ON_SOFT_TRIGGER+:2] == ACT_TGL
        |=> lineBOut != $past(lineBOut))
        else $error("line B not toggled on soft trigger");
    a_clk_off: assert property ( // [RULE_15]
        sClkOff ##1 !(restart || wrCtrl) ##1 rdSr |=> !rdata[ST_CLOCK_RUNNING_FLAG])
        else $error("clock status wrong after disable");
    // Each event must reach its own sticky bit in the next cycle
    a_overrun_flag: assert property ( // [RULE_09]
        sReload |=> flags_q[ST_LOVR])
        else $error("load overrun not flagged");
    a_match_c: assert property ( // [RULE_11]
        tick && cnt_q == rc_q |=> flags_q[ST_CPC])
        else $error("match C not flagged");
    a_ext_flag: assert property ( // [RULE_13]
        extEvent |=> flags_q[ST_ETRG])
        else $error("external trigger not flagged");
    a_load_a: assert property ( // [RULE_12]
        !wave && riseA && mode_q[MODE_LDRA+:2] == EDGE_RISE |=>
            flags_q[ST_LDA] && ra_q == $past(cnt_q))
        else $error("hold A not loaded on rise");
    a_load_b: assert property ( // [RULE_12]
        !wave && fallA && mode_q[MODE_LDRB+:2] == EDGE_FALL |=>
            flags_q[ST_LDB] && rb_q == $past(cnt_q))
        else $error("hold B not loaded on fall");
    // Mirrors are read through the status word one cycle later
    a_mirror_a: assert property ( // [RULE_16]
        rdSr |=> rdata[ST_MIRA] == $past(wave ? lineAOut : pinA_q))
        else $error("line A mirror wrong");
    a_mirror_b: assert property ( // [RULE_17]
        rdSr && lineBOe |=> rdata[ST_MIRB] == $past(lineBOut))
        else $error("line B mirror wrong");
    a_mask_read: assert property ( // [RULE_20]
        rdStb && addr == OFS_IMR |=> rdata == {24'h000000, $past(mask_q)})
        else $error("mask read wrong");
    a_mode_oe: assert property ( // [RULE_21]
        wrMode |=> lineAOe == $past(wdata[MODE_WAVE]))
        else $error("line A drive does not follow mode");
    a_clk_start: assert property ( // [RULE_15]
        swTrig && !wdata[CTRL_CLKDIS] |=> clkEn_q)
        else $error("soft trigger did not start clock");
    a_hold_wr: assert property ( // [RULE_06]
        wrRa |=> ra_q == $past(wdCnt))
        else $error("hold A not written in waveform mode");
    // Lines follow their action codes one edge after the event
    a_lineb_match_c: assert property ( // [RULE_02]
        wave && matchC && !trigEv && mode_q[MODE_LINE_B_ACTION_ON_MATCH_C+:2] == ACT_TGL
        |=> lineBOut != $past(lineBOut))
        else $error("line B not toggled on match C");
    a_lineb_ext: assert property ( // [RULE_03]
        wave && extEvent && !swTrig && mode_q[MODE_LINE_B_ACTION_ON_EXT_EVENT+:2] == ACT_CLR
        |=> !lineBOut)
        else $error("line B not cleared on external event");
endmodule : timer_channel

// *** sim/line_far_end.sv ***
`timescale 1ns/1ns
// ------------------------------------------------------------
// Far side of the two waveform/capture lines
// ------------------------------------------------------------
module line_far_end (
    input wire logic lineAOut,
    input wire logic lineAOe,
    input wire logic lineBOut,
    input wire logic lineBOe,
    input wire logic aLevel,
    input wire logic bLevel,
    output logic lineAIn,
    output logic lineBIn
);
    // The pin shows the channel's level while it drives, else ours
    assign lineAIn = lineAOe ? lineAOut : aLevel;
    assign lineBIn = lineBOe ? lineBOut : bLevel;
endmodule : line_far_end

// *** sim/timer_channel_regs_status_test.sv ***
`timescale 1ns/1ns
module timer_channel_regs_status_test;
    import timer_channel_pkg::*;
    logic ref_clk, rst, wrStb, rdStb, countTick, extEvent;
    logic aLevel, bLevel, lineAIn, lineBIn, lineAOut, lineAOe;
    logic lineBOut, lineBOe, irq;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, base;
    int n_errors, n_tests, cycles;
    logic [1:0] codes [4] = '{ACT_CLR, ACT_SET, ACT_NONE, ACT_TGL};
    logic levels [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

    timer_channel timer_channel_inst (.ref_clk(ref_clk), .rst(rst),
        .addr(addr), .wdata(wdata), .wrStb(wrStb), .rdStb(rdStb),
        .rdata(rdata), .countTick(countTick), .extEvent(extEvent),
        .lineAIn(lineAIn), .lineAOut(lineAOut), .lineAOe(lineAOe),
        .lineBIn(lineBIn), .lineBOut(lineBOut), .lineBOe(lineBOe),
        .irq(irq));
    line_far_end line_far_end_inst (.lineAOut(lineAOut),
        .lineAOe(lineAOe), .lineBOut(lineBOut), .lineBOe(lineBOe),
        .aLevel(aLevel), .bLevel(bLevel), .lineAIn(lineAIn),
        .lineBIn(lineBIn));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : idle

    // The extra edge keeps a strobe from being lowered and raised at once
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wrStb <= 1'b1;
        @(posedge ref_clk);
        wrStb <= 1'b0;
        @(posedge ref_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge ref_clk);
        rdStb <= 1'b0;
        @(negedge ref_clk);
        chk(rdata & m, e);
        @(posedge ref_clk);
    endtask : rd

    task automatic print_verdict;
        if (n_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    // Overflow run needs about 65600 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 90000) begin
            n_errors++;
            print_verdict();
        end
    end

    initial begin
        rst = 1'b1;
        {wrStb, rdStb, countTick, extEvent, aLevel, bLevel} = '0;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        idle(3);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd(OFS_CV, 32'hFFFF_FFFF, 32'h0000_0000);
        rd(OFS_SR, 32'h0001_00FF, 32'h0000_0000);
        rd(8'h3C, 32'hFFFF_FFFF, 32'h0000_0000);
        wr(OFS_RC, 32'hFFFF_1234);
        rd(OFS_RC, 32'hFFFF_FFFF, 32'h0000_1234);
        wr(OFS_RA, 32'h0000_0055);
        rd(OFS_RA, 32'hFFFF_FFFF, 32'h0000_0000);
        wr(OFS_IER, 32'h0000_00FF);
        rd(OFS_IMR, 32'hFFFF_FFFF, 32'h0000_00FF);
        wr(OFS_IDR, 32'h0000_000F);
        wr(OFS_IER, 32'h0000_0000);
        rd(OFS_IMR, 32'hFFFF_FFFF, 32'h0000_00F0);
        // Waveform mode, event source off line B so line B drives
        base = 32'h0000_8400;
        wr(OFS_MODE, base);
        wr(OFS_RA, 32'h0000_0005);
        rd(OFS_RA, 32'hFFFF_FFFF, 32'h0000_0005);
        for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < 4; i++) begin
                wr(OFS_MODE, base | ({30'h0, codes[i]} <<
                   (s == 0 ? MODE_LINE_B_ACTION_ON_SOFT_TRIGGER : MODE_LINE_B_ACTION_ON_EXT_EVENT)) |
                   ({30'h0, codes[i]} <<
                   (s == 0 ? MODE_ASWTRG : MODE_AEEVT)));
                if (s == 0) begin
                    wr(OFS_CTRL, 32'h0000_0004);
                end else begin
                    extEvent <= 1'b1;
                    @(posedge ref_clk);
                    extEvent <= 1'b0;
                end
                idle(3);
                chk({31'h0, lineBOut}, {31'h0, levels[i]});
                chk({31'h0, lineAOut}, {31'h0, levels[i]});
                chk({31'h0, lineBOe}, 32'h0000_0001);
                chk({31'h0, lineAOe}, 32'h0000_0001);
                rd(OFS_SR, 32'h0007_0080,
                   levels[i] ? 32'h0007_0080 : 32'h0001_0080);
            end
        end
        rd(OFS_SR, 32'h0000_0080, 32'h0000_0000);
        // Match B sets, match C toggles line B
        wr(OFS_MODE, base | (32'h1 << MODE_LINE_B_ACTION_ON_MATCH_B) |
           (32'h3 << MODE_LINE_B_ACTION_ON_MATCH_C));
        wr(OFS_RB, 32'h0000_0001);
        wr(OFS_RC, 32'h0000_0002);
        wr(OFS_CTRL, 32'h0000_0004);
        rd(OFS_SR, 32'h0000_0000, 32'h0000_0000);
        countTick <= 1'b1;
        idle(3);
        countTick <= 1'b0;
        idle(3);
        chk({31'h0, irq}, 32'h0000_0001);
        rd(OFS_SR, 32'h0005_00FF, 32'h0001_0018);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(OFS_CV, 32'h0000_0000);
        rd(OFS_CV, 32'hFFFF_FFFF, 32'h0000_0003);
        // Full wrap of the counter back to the same value
        countTick <= 1'b1;
        idle(65536);
        countTick <= 1'b0;
        idle(2);
        rd(OFS_SR, 32'h0000_0001, 32'h0000_0001);
        rd(OFS_CV, 32'hFFFF_FFFF, 32'h0000_0003);
        // Capture: A loads on rise, B on fall of line A
        wr(OFS_MODE, (32'h1 << MODE_LDRA) | (32'h2 << MODE_LDRB));
        wr(OFS_RA, 32'h0000_0077);
        rd(OFS_RA, 32'hFFFF_FFFF, 32'h0000_0005);
        rd(OFS_SR, 32'h0000_0000, 32'h0000_0000);
        chk({31'h0, lineAOe}, 32'h0000_0000);
        aLevel <= 1'b1;
        idle(8);
        aLevel <= 1'b0;
        idle(8);
        aLevel <= 1'b1;
        idle(8);
        rd(OFS_SR, 32'h0002_007F, 32'h0002_0062);
        rd(OFS_RA, 32'hFFFF_FFFF, 32'h0000_0003);
        wr(OFS_CTRL, 32'h0000_0002);
        rd(OFS_SR, 32'h0001_0000, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0001);
        rd(OFS_SR, 32'h0001_0000, 32'h0001_0000);
        print_verdict();
    end
endmodule : timer_channel_regs_status_test
